// ### design/flr_cfg.svh
// Constants of the fault record recorder: command codes, record layout, timing.
// Assumes an including file that needs them as plain macros.
`ifndef FLR_CFG_SVH
`define FLR_CFG_SVH

// Command codes seen on the management bus.
`define FLR_CMD_READ      8'hee
`define FLR_CMD_SAVE      8'hea
`define FLR_CMD_ERASE     8'hec

// Record layout, byte positions within the 147-byte block.
`define FLR_REC_LEN       8'h93
`define FLR_LAST_IDX      8'h92
`define FLR_POS_SOURCE    8'h04
`define FLR_POS_TS_FIRST  8'h05
`define FLR_POS_TS_LAST   8'h0a
`define FLR_POS_VPK0_HI   8'h0b
`define FLR_POS_VPK0_LO   8'h0c
`define FLR_POS_VPK1_HI   8'h0d
`define FLR_POS_VPK1_LO   8'h0e
`define FLR_POS_IPK0_HI   8'h0f
`define FLR_POS_IPK0_LO   8'h10
`define FLR_POS_IPK1_HI   8'h11
`define FLR_POS_IPK1_LO   8'h12
`define FLR_PAGE4_START   8'h57
`define FLR_PAGE5_START   8'h6b
`define FLR_PAGE_LEN      8'h14

// Preface characters; the values are arbitrary.
`define FLR_PREFACE0      8'h46
`define FLR_PREFACE1      8'h52
`define FLR_PREFACE2      8'h30
`define FLR_PREFACE3      8'h31

// Non-volatile presence marker kept beyond the record.
`define FLR_MARK_ADDR     8'h93
`define FLR_MARK_VAL      8'ha5
`define FLR_MARK_NONE     8'h00
`define FLR_STORE_DEPTH   148

// Die temperature hysteresis in degrees Celsius, signed 10 bits.
`define FLR_TEMP_HOT      10'sh082
`define FLR_TEMP_COOL     10'sh07d

// Timing: clock period, up-time tick and the early window after power-up.
`define FLR_CLK_NS        20
`define FLR_TICK_NS       200000
`define FLR_TICK_CYCLES   (`FLR_TICK_NS / `FLR_CLK_NS)
`define FLR_TICK_US       200
`define FLR_EARLY_US      1000000
`define FLR_EARLY_TICKS   (`FLR_EARLY_US / `FLR_TICK_US)

`endif

// ### design/flr_pkg.sv
// Types shared by the fault record recorder files.
// Assumes the configuration header is on the include path.
package flr_pkg;
    typedef enum logic [2:0] {
        S_BOOT,
        S_BOOT_WAIT,
        S_IDLE,
        S_CAP,
        S_MARK,
        S_ERASE,
        S_RD_SEND,
        S_RD_LOAD
    } flr_state_t;

    typedef logic [7:0] flr_byte_t;
endpackage

// ### design/flr_store.sv
// Byte store standing in for the non-volatile fault record area.
// Assumes one writer and one reader on the same clock; contents have no reset.
`timescale 1ns/100ps
module flr_store
    import flr_pkg::*;
#(
    parameter int DEPTH = 148,
    parameter int AW    = 8
) (
    input  wire logic          clock_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire flr_byte_t     wdata_i,
    input  wire logic          re_i,
    input  wire logic [AW-1:0] raddr_i,
    output flr_byte_t          rdata_o
);
    // Contents deliberately escape reset so that they behave as non-volatile.
    flr_byte_t mem_q [DEPTH];
    flr_byte_t rdata_q;

    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (re_i) begin
            rdata_q <= mem_q[raddr_i];
        end
    end

    assign rdata_o = rdata_q;
endmodule

// ### design/flr_recorder.sv
// Fault record recorder: capture of the fault record into storage and block readout.
// Assumes commands, telemetry and fault events come from logic on clock_i.
`timescale 1ns/100ps
`include "flr_cfg.svh"
module flr_recorder
    import flr_pkg::*;
#(
    parameter int TICK_CYCLES = `FLR_TICK_CYCLES
) (
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    input  wire logic              cmd_valid_i,
    output logic                   cmd_ready_o,
    input  wire flr_byte_t         cmd_code_i,
    input  wire logic              cmd_read_i,
    input  wire logic              cmd_has_data_i,
    output logic                   cmd_refused_o,
    output logic                   rd_valid_o,
    input  wire logic              rd_ready_i,
    output flr_byte_t              rd_byte_o,
    output logic                   rd_last_o,
    input  wire logic              fault_event_i,
    input  wire flr_byte_t         fault_source_i,
    input  wire logic              fault_log_enable_i,
    output logic                   fault_status_o,
    input  wire logic              module_reset_i,
    input  wire logic signed [9:0] die_temp_i,
    input  wire logic              telem_valid_i,
    input  wire logic [15:0]       vout0_i,
    input  wire logic [15:0]       vout1_i,
    input  wire logic [15:0]       iout0_i,
    input  wire logic [15:0]       iout1_i,
    input  wire logic              peak_reset_i,
    output flr_byte_t              ram_log_addr_o,
    input  wire flr_byte_t         ram_log_byte_i,
    output logic                   record_present_o,
    output logic                   record_early_o,
    output logic                   busy_o
);
    flr_state_t  state_q;
    flr_byte_t   idx_q;
    flr_byte_t   rd_byte_q;
    logic        rd_last_q;
    logic        present_q;
    logic        from_ram_q;
    logic        early_q;
    logic        hot_q;
    logic        pend_q;
    flr_byte_t   src_q;
    logic [47:0] ts_q;
    logic [47:0] uptime_q;
    logic [13:0] div_q;
    logic        tick;
    logic        refused_q;
    logic        status_q;
    logic [15:0] vpk0_q;
    logic [15:0] vpk1_q;
    logic [15:0] ipk0_q;
    logic [15:0] ipk1_q;
    logic        accept;
    logic        is_read;
    logic        is_save;
    logic        is_erase;
    logic        save_ok;
    logic        st_we;
    flr_byte_t   st_waddr;
    flr_byte_t   st_wdata;
    logic        st_re;
    flr_byte_t   st_raddr;
    flr_byte_t   st_rdata;
    flr_byte_t   hdr_byte;
    flr_byte_t   page_off;

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.

    assign cmd_ready_o = (state_q == S_IDLE) && !pend_q;
    assign accept      = cmd_valid_i && cmd_ready_o;
    // only a block read selects readout.
    assign is_read     = accept && (cmd_code_i == `FLR_CMD_READ) && cmd_read_i;
    assign is_save     = accept && (cmd_code_i == `FLR_CMD_SAVE) && !cmd_read_i
                         && !cmd_has_data_i;
    assign save_ok     = is_save && !hot_q;
    assign is_erase    = accept && (cmd_code_i == `FLR_CMD_ERASE) && !cmd_read_i
                         && !cmd_has_data_i;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            refused_q <= 1'b0;
        end else begin
            refused_q <= accept
                         && ((cmd_code_i == `FLR_CMD_READ && !cmd_read_i)
                             || ((cmd_code_i == `FLR_CMD_SAVE
                                  || cmd_code_i == `FLR_CMD_ERASE)
                                 && (cmd_read_i || cmd_has_data_i))
                             || (is_save && hot_q));
        end
    end

    // status pulse on an accepted force-save while fault_log_enable_i is high.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_q <= 1'b0;
        end else begin
            status_q <= save_ok && fault_log_enable_i;
        end
    end

    // hysteresis between 130 and 125 degrees.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hot_q <= 1'b0;
        end else if (die_temp_i > `FLR_TEMP_HOT) begin
            hot_q <= 1'b1;
        end else if (die_temp_i < `FLR_TEMP_COOL) begin
            hot_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Up-time counter and peaks.

    // fixed divider from the controller clock.
    assign tick = (div_q == 14'(TICK_CYCLES - 1));

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= 14'h0000;
        end else if (module_reset_i || tick) begin
            div_q <= 14'h0000;
        end else begin
            div_q <= div_q + 14'h0001;
        end
    end

    // binary count of 200 us ticks.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            uptime_q <= 48'h0;
        end else if (module_reset_i) begin
            uptime_q <= 48'h0;
        end else if (tick) begin
            uptime_q <= uptime_q + 48'h1;
        end
    end

    // Peaks compare raw words unsigned, so a current below zero in signed form is tracked as a large peak.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vpk0_q <= 16'h0000;
            vpk1_q <= 16'h0000;
            ipk0_q <= 16'h0000;
            ipk1_q <= 16'h0000;
        end else if (peak_reset_i) begin
            vpk0_q <= 16'h0000;
            vpk1_q <= 16'h0000;
            ipk0_q <= 16'h0000;
            ipk1_q <= 16'h0000;
        end else if (telem_valid_i) begin
            vpk0_q <= (vout0_i > vpk0_q) ? vout0_i : vpk0_q;
            vpk1_q <= (vout1_i > vpk1_q) ? vout1_i : vpk1_q;
            ipk0_q <= (iout0_i > ipk0_q) ? iout0_i : ipk0_q;
            ipk1_q <= (iout1_i > ipk1_q) ? iout1_i : ipk1_q;
        end
    end

    // A fault is held pending so one that arrives during a transfer is not lost.
    // Events during a capture are dropped, so the header being written stays whole.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_q <= 1'b0;
            src_q  <= 8'h00;
            ts_q   <= 48'h0;
        end else if ((fault_event_i || save_ok) && state_q != S_CAP) begin
            pend_q <= 1'b1;
            src_q  <= fault_event_i ? fault_source_i : 8'h00;
            ts_q   <= uptime_q;
        end else if (state_q == S_IDLE) begin
            pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Record header bytes.

    always_comb begin
        hdr_byte = ram_log_byte_i;
        unique case (idx_q)
            8'h00: hdr_byte = `FLR_PREFACE0;
            8'h01: hdr_byte = `FLR_PREFACE1;
            8'h02: hdr_byte = `FLR_PREFACE2;
            8'h03: hdr_byte = `FLR_PREFACE3;
            // source then timestamp, least significant first.
            `FLR_POS_SOURCE: hdr_byte = src_q;
            8'h05: hdr_byte = ts_q[7:0];
            8'h06: hdr_byte = ts_q[15:8];
            8'h07: hdr_byte = ts_q[23:16];
            8'h08: hdr_byte = ts_q[31:24];
            8'h09: hdr_byte = ts_q[39:32];
            `FLR_POS_TS_LAST: hdr_byte = ts_q[47:40];
            // channel 0 voltage peak, high first.
            `FLR_POS_VPK0_HI: hdr_byte = vpk0_q[15:8];
            `FLR_POS_VPK0_LO: hdr_byte = vpk0_q[7:0];
            // channel 1 voltage peak, high first.
            `FLR_POS_VPK1_HI: hdr_byte = vpk1_q[15:8];
            `FLR_POS_VPK1_LO: hdr_byte = vpk1_q[7:0];
            // current peaks kept in linear 11 words.
            `FLR_POS_IPK0_HI: hdr_byte = ipk0_q[15:8];
            `FLR_POS_IPK0_LO: hdr_byte = ipk0_q[7:0];
            `FLR_POS_IPK1_HI: hdr_byte = ipk1_q[15:8];
            `FLR_POS_IPK1_LO: hdr_byte = ipk1_q[7:0];
            default: hdr_byte = ram_log_byte_i;
        endcase
    end

    assign ram_log_addr_o = idx_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer for boot, capture, erase and readout.

    // pages five and six of a record found at boot read back as page four.
    assign page_off = (idx_q - `FLR_PAGE5_START >= `FLR_PAGE_LEN)
                      ? idx_q - `FLR_PAGE5_START - `FLR_PAGE_LEN
                      : idx_q - `FLR_PAGE5_START;

    always_comb begin
        st_we    = 1'b0;
        st_waddr = idx_q;
        st_wdata = hdr_byte;
        st_re    = 1'b0;
        st_raddr = idx_q;
        unique case (state_q)
            S_BOOT: begin
                st_re    = 1'b1;
                st_raddr = `FLR_MARK_ADDR;
            end
            // copy of the RAM record into storage.
            S_CAP: st_we = 1'b1;
            S_MARK: begin
                st_we    = 1'b1;
                st_waddr = `FLR_MARK_ADDR;
                st_wdata = `FLR_MARK_VAL;
            end
            S_ERASE: begin
                st_we    = 1'b1;
                st_waddr = `FLR_MARK_ADDR;
                st_wdata = `FLR_MARK_NONE;
            end
            S_RD_SEND: begin
                st_re = rd_ready_i && !rd_last_q;
                if (!from_ram_q && idx_q >= `FLR_PAGE5_START) begin
                    st_raddr = `FLR_PAGE4_START + page_off;
                end
            end
            default: st_re = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q   <= S_BOOT;
            idx_q     <= 8'h00;
            rd_byte_q <= 8'h00;
            rd_last_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_BOOT:      state_q <= S_BOOT_WAIT;
                S_BOOT_WAIT: state_q <= S_IDLE;
                S_IDLE: begin
                    idx_q <= 8'h00;
                    // a stored record blocks a new capture.
                    if (pend_q && !present_q) begin
                        state_q <= S_CAP;
                    end else if (is_erase) begin
                        state_q <= S_ERASE;
                    end else if (is_read) begin
                        // zero length when nothing is stored.
                        rd_byte_q <= present_q ? `FLR_REC_LEN : 8'h00;
                        rd_last_q <= !present_q;
                        state_q   <= S_RD_SEND;
                    end
                end
                S_CAP: begin
                    idx_q <= idx_q + 8'h01;
                    if (idx_q == `FLR_LAST_IDX) begin
                        state_q <= S_MARK;
                    end
                end
                S_MARK:  state_q <= S_IDLE;
                S_ERASE: state_q <= S_IDLE;
                S_RD_SEND: begin
                    if (rd_ready_i) begin
                        state_q <= rd_last_q ? S_IDLE : S_RD_LOAD;
                    end
                end
                S_RD_LOAD: begin
                    rd_byte_q <= st_rdata;
                    rd_last_q <= (idx_q == `FLR_LAST_IDX);
                    idx_q     <= idx_q + 8'h01;
                    state_q   <= S_RD_SEND;
                end
            endcase
        end
    end

    // presence follows the stored marker across resets.
    // set at boot from the marker, otherwise only by a completed capture.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            present_q  <= 1'b0;
            from_ram_q <= 1'b0;
            early_q    <= 1'b0;
        end else if (state_q == S_BOOT_WAIT) begin
            present_q <= (st_rdata == `FLR_MARK_VAL);
        end else if (state_q == S_MARK) begin
            present_q  <= 1'b1;
            from_ram_q <= 1'b1;
            // capture inside the first second is flagged.
            early_q    <= (ts_q < 48'(`FLR_EARLY_TICKS));
        end else if (state_q == S_ERASE) begin
            present_q  <= 1'b0;
            from_ram_q <= 1'b0;
            early_q    <= 1'b0;
        end
    end

    flr_store #(
        .DEPTH (`FLR_STORE_DEPTH),
        .AW    (8)
    ) u_store (
        .clock_i (clock_i),
        .we_i    (st_we),
        .waddr_i (st_waddr),
        .wdata_i (st_wdata),
        .re_i    (st_re),
        .raddr_i (st_raddr),
        .rdata_o (st_rdata)
    );

    assign rd_valid_o       = (state_q == S_RD_SEND);
    assign rd_byte_o        = rd_byte_q;
    assign rd_last_o        = rd_last_q;
    assign cmd_refused_o    = refused_q;
    assign fault_status_o   = status_q;
    assign record_present_o = present_q;
    assign record_early_o   = early_q;
    assign busy_o           = (state_q != S_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence seq_read_empty;
        is_read && !present_q;
    endsequence

    sequence seq_zero_block;
        rd_valid_o && rd_byte_o == 8'h00 && rd_last_o;
    endsequence

    a_empty_len_zero:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        seq_read_empty |=> seq_zero_block)
        else $error("empty record did not read length zero");

    a_full_len_byte:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        is_read && present_q |=> rd_valid_o && rd_byte_o == 8'h93 && !rd_last_o)
        else $error("stored record length byte wrong");

    a_last_at_end:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        state_q == S_RD_LOAD && idx_q == 8'h92 |=> rd_last_o && rd_valid_o)
        else $error("last byte not at index 146");

    a_hot_save_ignored:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        is_save && hot_q && !pend_q && !fault_event_i |=> !pend_q && cmd_refused_o)
        else $error("force-save taken while hot");

    a_hot_holds:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        hot_q && die_temp_i >= 10'sh07d |=> hot_q)
        else $error("hot state left above 125 degrees");

    a_status_raise:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        save_ok && fault_log_enable_i |=> fault_status_o)
        else $error("status not raised on force-save");

    a_tick_count:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        tick && !module_reset_i |=> uptime_q == $past(uptime_q) + 48'h1 && div_q == 14'h0)
        else $error("up-time did not advance on tick");

    a_uptime_restart:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        module_reset_i |=> uptime_q == 48'h0)
        else $error("up-time not restarted");

    a_erase_empties:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        is_erase && !pend_q |=> ##1 !present_q && state_q == S_IDLE)
        else $error("erase left a record present");

    a_record_locked:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        present_q && state_q == S_IDLE |=> state_q != S_CAP)
        else $error("stored record overwritten");

    a_ts_low_first:
    assert property (@(posedge clock_i) disable iff (!resetn_i)
        st_we && st_waddr == 8'h05 |-> st_wdata == ts_q[7:0])
        else $error("timestamp low byte misplaced");
endmodule

// ### verification/flr_ram_model.sv
// RAM log model feeding the recorder its cyclical bytes during capture.
// Assumes a combinational answer for the index the recorder presents.
`timescale 1ns/100ps
module flr_ram_model
    import flr_pkg::*;
(
    input  wire flr_byte_t addr_i,
    output flr_byte_t      data_o
);
    // Each index holds a distinct byte so a shifted copy is caught.
    assign data_o = addr_i ^ 8'h5a;
endmodule

// ### verification/testbench.sv
// Testbench of the fault record recorder: commands, captures and record readout.
// Assumes the design files and the RAM log model are compiled before it.
`timescale 1ns/100ps
`include "flr_cfg.svh"
module testbench
    import flr_pkg::*;
;
    logic              clock_i, resetn_i, cmd_valid, cmd_read, cmd_data, fault_ev, log_en;
    logic              mod_rst, telem, pk_rst, cmd_ready, refused, rd_valid, rd_last, status;
    logic              present, early, busy, rd_rdy;
    logic signed [9:0] temp;
    logic [15:0]       v0, v1, i0, i1;
    flr_byte_t         cmd_code, src, rd_byte, ram_addr, ram_byte;
    flr_byte_t         rec [147];
    int                n_fail = 0;
    int                check_count = 0;

    flr_recorder #(.TICK_CYCLES(10)) uut (.clock_i(clock_i), .resetn_i(resetn_i),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_code_i(cmd_code),
        .cmd_read_i(cmd_read), .cmd_has_data_i(cmd_data), .cmd_refused_o(refused),
        .rd_valid_o(rd_valid), .rd_ready_i(rd_rdy), .rd_byte_o(rd_byte), .rd_last_o(rd_last),
        .fault_event_i(fault_ev), .fault_source_i(src), .fault_log_enable_i(log_en),
        .fault_status_o(status), .module_reset_i(mod_rst), .die_temp_i(temp),
        .telem_valid_i(telem), .vout0_i(v0), .vout1_i(v1), .iout0_i(i0), .iout1_i(i1),
        .peak_reset_i(pk_rst), .ram_log_addr_o(ram_addr), .ram_log_byte_i(ram_byte),
        .record_present_o(present), .record_early_o(early), .busy_o(busy));
    flr_ram_model ram (.addr_i(ram_addr), .data_o(ram_byte));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input flr_byte_t seen, input flr_byte_t exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // Offers one command, holds it until taken, then, except for a block read, judges the pulses of the next cycle.
    task automatic cmd(input flr_byte_t code, input logic rd, input logic dat,
                       input logic exp_ref, input logic exp_st);
        int n;
        n = 0;
        cmd_code  <= code;
        cmd_read  <= rd;
        cmd_data  <= dat;
        cmd_valid <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (cmd_ready !== 1'b1 && n < 400);
        cmd_valid <= 1'b0;
        if (code == `FLR_CMD_READ && rd) return;
        @(posedge clock_i);
        check({7'h0, refused}, {7'h0, exp_ref});
        check({7'h0, status}, {7'h0, exp_st});
    endtask

    task automatic rd1(output flr_byte_t b, output logic last);
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (rd_valid !== 1'b1 && n < 10);
        b = rd_byte;
        last = rd_last;
    endtask

    task automatic read_rec(input logic full, input logic rep, input logic pk,
                            input flr_byte_t s, input flr_byte_t lo, input flr_byte_t hi);
        flr_byte_t   b, e;
        logic        last;
        logic [63:0] pkv;
        pkv = pk ? 64'h1234_0789_0abc_0222 : 64'h0;
        rd_rdy <= 1'b0;
        cmd(`FLR_CMD_READ, 1'b1, 1'b0, 1'b0, 1'b0);
        // The sink stalls the length byte, which must stand until it is taken.
        tick(3);
        check({7'h0, rd_valid}, 8'h01);
        rd_rdy <= 1'b1;
        rd1(b, last);
        check(b, full ? `FLR_REC_LEN : 8'h00);
        if (!full) begin
            check({7'h0, last}, 8'h01);
            return;
        end
        for (int i = 0; i < 147; i++) begin
            rd1(rec[i], last);
            check({7'h0, last}, {7'h0, i == 146});
        end
        check(rec[0], `FLR_PREFACE0);
        check(rec[1], `FLR_PREFACE1);
        check(rec[2], `FLR_PREFACE2);
        check(rec[3], `FLR_PREFACE3);
        check(rec[4], s);
        check({7'h0, rec[5] >= lo && rec[5] <= hi}, 8'h01);
        for (int i = 6; i < 11; i++) begin
            check(rec[i], 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            check(rec[11 + i], pkv[63 - 8 * i -: 8]);
        end
        for (int i = 19; i < 147; i++) begin
            e = (rep && i >= 107) ? 8'(87 + (i - 107) % 20) : 8'(i);
            check(rec[i], e ^ 8'h5a);
        end
    endtask

    task automatic pulse_fault(input flr_byte_t s);
        src      <= s;
        fault_ev <= 1'b1;
        tick(1);
        fault_ev <= 1'b0;
        tick(200);
    endtask

    task automatic telem_set(input logic [63:0] w);
        {v0, v1, i0, i1} <= w;
        telem            <= 1'b1;
        tick(1);
        telem            <= 1'b0;
        tick(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {cmd_valid, cmd_read, cmd_data, fault_ev, log_en, mod_rst, telem, pk_rst} = 8'h00;
        cmd_code = 8'h00;
        src = 8'h00;
        rd_rdy = 1'b1;
        temp = 10'sd25;
        {v0, v1, i0, i1} = 64'h0;
        resetn_i = 1'b0;
        tick(2);
        resetn_i <= 1'b1;
        tick(4);
        cmd(`FLR_CMD_ERASE, 1'b0, 1'b0, 1'b0, 1'b0);
        tick(2);
        check({7'h0, present}, 8'h00);
        read_rec(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        cmd(`FLR_CMD_READ, 1'b0, 1'b0, 1'b1, 1'b0);
        cmd(`FLR_CMD_SAVE, 1'b0, 1'b1, 1'b1, 1'b0);
        cmd(`FLR_CMD_ERASE, 1'b1, 1'b0, 1'b1, 1'b0);
        temp <= 10'sd131;
        tick(2);
        cmd(`FLR_CMD_SAVE, 1'b0, 1'b0, 1'b1, 1'b0);
        temp <= 10'sd127;
        tick(2);
        cmd(`FLR_CMD_SAVE, 1'b0, 1'b0, 1'b1, 1'b0);
        temp <= 10'sd124;
        pk_rst <= 1'b1;
        tick(1);
        pk_rst <= 1'b0;
        telem_set(64'h1234_0456_0abc_0011);
        telem_set(64'h1000_0789_0123_0222);
        mod_rst <= 1'b1;
        tick(1);
        mod_rst <= 1'b0;
        log_en  <= 1'b1;
        tick(99);
        cmd(`FLR_CMD_SAVE, 1'b0, 1'b0, 1'b0, 1'b1);
        tick(1);
        check({7'h0, busy}, 8'h01);
        read_rec(1'b1, 1'b0, 1'b1, 8'h00, 8'h09, 8'h0b);
        check({7'h0, present}, 8'h01);
        check({7'h0, early}, 8'h01);
        pulse_fault(8'h77);
        read_rec(1'b1, 1'b0, 1'b1, 8'h00, 8'h09, 8'h0b);
        resetn_i <= 1'b0;
        tick(2);
        resetn_i <= 1'b1;
        tick(4);
        check({7'h0, present}, 8'h01);
        read_rec(1'b1, 1'b1, 1'b1, 8'h00, 8'h09, 8'h0b);
        log_en <= 1'b0;
        cmd(`FLR_CMD_ERASE, 1'b0, 1'b0, 1'b0, 1'b0);
        read_rec(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        pulse_fault(8'h3c);
        read_rec(1'b1, 1'b0, 1'b0, 8'h3c, 8'h00, 8'hff);
        report_and_stop();
    end

    initial begin
        tick(20000);
        n_fail++;
        report_and_stop();
    end
endmodule
